// *** offset_trim_cfg.svh ***
// register map, field layout, reset values and timing of the offset trim bank
`ifndef OFFSET_TRIM_CFG_SVH
`define OFFSET_TRIM_CFG_SVH

// register indices; byte address on the bus is four times the index
`define CORE2_INPUT_B_OFFSET_TRIM_IDX 12'h336
`define CORE3_INPUT_C_OFFSET_TRIM_IDX 12'h338
`define CORE3_INPUT_D_OFFSET_TRIM_IDX 12'h33a
`define CORE4_OFFSET_TRIM_IDX         12'h33c
`define CORE5_OFFSET_TRIM_IDX         12'h33e
`define TRIM_CONTROL_IDX              12'h340
`define TRIM_STATUS_IDX               12'h341

// field layout of each trim register
`define TRIM_FIELD_MSB    11
`define TRIM_FIELD_LSB    0
`define TRIM_RSVD_MSB     15
`define TRIM_RSVD_LSB     12
`define TRIM_REG_RESET    16'h0000

// control register bits
`define CTRL_RELOAD_BIT   0
// status register bits
`define STAT_LOADED_BIT   0
`define STAT_CAL_BIT      1
`define STAT_LOADING_BIT  2

// fuse copy takes one cycle
`define FUSE_LOAD_CYCLES  1

`endif

// *** offset_trim_pkg.sv ***
// types shared by the offset trim bank
package offset_trim_pkg;

  localparam int TRIM_COUNT = 5;
  localparam int TRIM_W     = 12;

  // one trim field per register, entry order follows the register map
  typedef logic [TRIM_COUNT-1:0][TRIM_W-1:0] trim_vec_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } trim_state_e;

  // corrections handed to the converter cores
  typedef struct packed {
    logic [TRIM_W-1:0] core2;
    logic              core2_valid;
    logic [TRIM_W-1:0] core3;
    logic [TRIM_W-1:0] core4;
    logic [TRIM_W-1:0] core5;
  } core_offsets_s;

endpackage

// *** offset_trim_bank.sv ***
// offset trim register bank with wishbone slave and per-core correction mux
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "offset_trim_cfg.svh"
//
// Functional notes
// RULE_01 - core 2 on input b uses bits 11:0 of the core2 b trim register.
// RULE_02 - core 3 on input c uses bits 11:0 of the core3 c trim register.
// RULE_03 - core 3 on input d uses bits 11:0 of the core3 d trim register.
// RULE_04 - every core 4 sample uses bits 11:0 of the core4 trim register.
// RULE_05 - every core 5 sample uses bits 11:0 of the core5 trim register.
// RULE_06 - each trim field is loaded with its factory value from fuses.
// RULE_07 - software writes zero into reserved bits 15:12 of each trim.
// RULE_08 - each trim register is 16-bit read/write and resets to zero.
// RULE_09 - every 12-bit trim field is an unsigned number.
// RULE_10 - software leaves the trims alone while offset calibration runs.
// RULE_11 - a shared core picks its trim combinationally from its input.

module offset_trim_bank
  import offset_trim_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // wishbone classic slave
  input  wire logic          cyc_i,
  input  wire logic          stb_i,
  input  wire logic          we_i,
  input  wire logic [13:0]   adr_i,
  input  wire logic [3:0]    sel_i,
  input  wire logic [31:0]   dat_i,
  output logic      [31:0]   dat_o,
  output logic               ack_o,
  // fuse storage and calibration engine, same clock
  input  wire trim_vec_t     fuse_trim_i,
  input  wire logic          cal_offset_busy_i,
  // current input selection of the shared cores
  input  wire logic          core2_sel_b_i,
  input  wire logic          core3_sel_d_i,
  output core_offsets_s      offsets_o
);

  localparam logic [11:0] IDX_TAB [TRIM_COUNT] = '{
    `CORE2_INPUT_B_OFFSET_TRIM_IDX,
    `CORE3_INPUT_C_OFFSET_TRIM_IDX,
    `CORE3_INPUT_D_OFFSET_TRIM_IDX,
    `CORE4_OFFSET_TRIM_IDX,
    `CORE5_OFFSET_TRIM_IDX
  };

  logic [15:0]     trim_reg [TRIM_COUNT];
  trim_state_e     state_reg;
  trim_state_e     state_next;
  logic            loaded_reg;
  logic            ack_reg;
  logic [31:0]     rdata_reg;
  logic [31:0]     rdata_next;
  logic [11:0]     word_idx;
  logic            bus_req;
  logic            wr_take;
  logic            ctrl_hit;
  logic            stat_hit;
  logic [TRIM_COUNT-1:0] trim_hit;
  logic [TRIM_W-1:0] trim_field [TRIM_COUNT];

  // word index of the request; bits 1:0 of the byte address are ignored
  assign word_idx = adr_i[13:2];
  // requests stall while the fuse copy is in progress
  assign bus_req  = cyc_i && stb_i && (state_reg == ST_RUN);
  // a write lands on the edge where the master sees ack high
  assign wr_take  = ce_i && bus_req && we_i && ack_reg;
  assign ctrl_hit = (word_idx == `TRIM_CONTROL_IDX);
  assign stat_hit = (word_idx == `TRIM_STATUS_IDX);

  // sequencer: copy fuses once after reset or on a reload request
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_LOAD: state_next = ST_RUN;
      ST_RUN: begin
        if (wr_take && ctrl_hit && sel_i[0] && dat_i[`CTRL_RELOAD_BIT]) begin
          state_next = ST_LOAD;
        end
      end
      default: state_next = ST_LOAD;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_LOAD;
    end else if (ce_i) begin
      state_reg <= state_next;
    end
  end

  // loaded flag stays set once the first fuse copy is done
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loaded_reg <= 1'b0;
    end else if (ce_i && state_reg == ST_LOAD) begin
      loaded_reg <= 1'b1;
    end
  end

  // trim registers, one per entry
  generate
    for (genvar g = 0; g < TRIM_COUNT; g++) begin : g_trim
      assign trim_hit[g] = (word_idx == IDX_TAB[g]);
      assign trim_field[g] = trim_reg[g][`TRIM_FIELD_MSB:`TRIM_FIELD_LSB];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          trim_reg[g] <= `TRIM_REG_RESET; // RULE_08
        end else if (ce_i && state_reg == ST_LOAD) begin
          // reserved bits cleared, field takes the factory value
          trim_reg[g] <= {4'h0, fuse_trim_i[g]}; // RULE_06
        end else if (wr_take && trim_hit[g]) begin
          // each byte lane stored when its sel_i bit is set; reserved bits keep what software wrote
          if (sel_i[0]) begin
            trim_reg[g][7:0] <= dat_i[7:0]; // RULE_08
          end
          if (sel_i[1]) begin
            trim_reg[g][15:8] <= dat_i[15:8]; // RULE_08
          end
        end
      end
    end
  endgenerate

  // read mux; unmapped words read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    for (int k = 0; k < TRIM_COUNT; k++) begin
      if (trim_hit[k]) begin
        rdata_next = {16'h0000, trim_reg[k]};
      end
    end
    if (stat_hit) begin
      rdata_next[`STAT_LOADED_BIT]  = loaded_reg;
      rdata_next[`STAT_CAL_BIT]     = cal_offset_busy_i;
      rdata_next[`STAT_LOADING_BIT] = (state_reg == ST_LOAD);
    end
  end

  // single-cycle ack; dropped the cycle after, so each request gets one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else if (ce_i) begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // read data captured with the ack so it is stable while ack is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i && bus_req && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = rdata_reg;

  // corrections; the shared-core mux is combinational so an input change
  // and its first sample see the new value in the same cycle
  always_comb begin
    offsets_o.core2       = trim_field[0]; // RULE_01
    offsets_o.core2_valid = core2_sel_b_i; // RULE_11
    offsets_o.core3       = core3_sel_d_i ?
      trim_field[2] : // RULE_03
      trim_field[1]; // RULE_02
    // unsigned fields: passed with no sign extension
    offsets_o.core4       = trim_field[3]; // RULE_04 RULE_09
    offsets_o.core5       = trim_field[4]; // RULE_05
  end

  // core 4 takes its own register for every sample
  logic [11:0] core4_field;
  assign core4_field = trim_reg[3][`TRIM_FIELD_MSB:`TRIM_FIELD_LSB]; // RULE_04

  // checks

  core2_b_apply_a: assert property ( // RULE_01
    @(posedge clk_i) disable iff (rst_i)
    core2_sel_b_i |-> offsets_o.core2_valid &&
      offsets_o.core2 == trim_reg[0][11:0])
    else $error("core2 input b correction wrong");

  core3_c_apply_a: assert property ( // RULE_02
    @(posedge clk_i) disable iff (rst_i)
    !core3_sel_d_i |-> offsets_o.core3 == trim_reg[1][11:0])
    else $error("core3 input c correction wrong");

  core3_d_apply_a: assert property ( // RULE_03
    @(posedge clk_i) disable iff (rst_i)
    core3_sel_d_i |-> offsets_o.core3 == trim_reg[2][11:0])
    else $error("core3 input d correction wrong");

  core4_apply_a: assert property ( // RULE_04
    @(posedge clk_i) disable iff (rst_i)
    offsets_o.core4 == core4_field && core4_field == trim_reg[3][11:0])
    else $error("core4 correction wrong");

  core5_apply_a: assert property ( // RULE_05
    @(posedge clk_i) disable iff (rst_i)
    offsets_o.core5 == trim_reg[4][11:0])
    else $error("core5 correction wrong");

  fuse_copy_a: assert property ( // RULE_06
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && state_reg == ST_LOAD) |=>
      trim_reg[0] == {4'h0, $past(fuse_trim_i[0])} &&
      trim_reg[4] == {4'h0, $past(fuse_trim_i[4])} &&
      state_reg == ST_RUN && loaded_reg)
    else $error("fuse copy did not land");

  reset_zero_a: assert property ( // RULE_08
    @(posedge clk_i)
    rst_i |=> trim_reg[1] == 16'h0000 && trim_reg[3] == 16'h0000 &&
      state_reg == ST_LOAD && !ack_o)
    else $error("trim register not zero after reset");

  write_land_a: assert property ( // RULE_08
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && trim_hit[3] && sel_i[1:0] == 2'b11) |=>
      trim_reg[3] == $past(dat_i[15:0]))
    else $error("trim write lost");

  ack_pulse_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && ack_o) |=> !ack_o)
    else $error("ack held longer than one cycle");

  ack_answer_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bus_req && !ack_o) |=> ack_o ##1 !ack_o)
    else $error("ack not given one cycle after request");

  unsigned_field_a: assert property ( // RULE_09
    @(posedge clk_i) disable iff (rst_i)
    ($rose(ack_o) && trim_hit[4] && !$past(we_i)) |->
      dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");

  // a low clock enable freezes the handshake, state and registers
  ce_freeze_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ce_i |=> $stable(ack_o) && $stable(state_reg) && $stable(dat_o) &&
      $stable(trim_reg[4]))
    else $error("state moved while clock enable low");

  // no answer and no write while the fuse copy runs
  load_no_ack_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_reg == ST_LOAD) |-> !ack_o && !wr_take)
    else $error("bus answered during fuse copy");

  // a reload write starts a fresh fuse copy on the next edge
  reload_start_a: assert property ( // RULE_06
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && ctrl_hit && sel_i[0] && dat_i[`CTRL_RELOAD_BIT]) |=>
      state_reg == ST_LOAD)
    else $error("reload write did not start a fuse copy");

  // the fuse copy leaves the reserved bits at zero
  rsvd_clear_a: assert property ( // RULE_06
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && state_reg == ST_LOAD) |=>
      trim_reg[2][`TRIM_RSVD_MSB:`TRIM_RSVD_LSB] == 4'h0)
    else $error("reserved bits not cleared by fuse copy");

  // reserved bits are stored as written, so software reads its own value
  rsvd_store_a: assert property ( // RULE_08
    @(posedge clk_i) disable iff (rst_i)
    (wr_take && trim_hit[1] && sel_i[1]) |=>
      trim_reg[1][`TRIM_RSVD_MSB:`TRIM_RSVD_LSB] == $past(dat_i[15:12]))
    else $error("reserved bits not stored");

  // read data is the register as it stood at the taken edge
  read_capture_a: assert property ( // RULE_08
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bus_req && !ack_o && !we_i && trim_hit[2]) |=>
      dat_o == {16'h0000, $past(trim_reg[2])})
    else $error("trim read data wrong");

  // words outside the map read as zero
  unmapped_zero_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bus_req && !ack_o && !we_i && !(|trim_hit) && !stat_hit) |=>
      dat_o == 32'h0000_0000)
    else $error("unmapped word did not read zero");

  // status shows the loaded flag and the calibration engine's busy level
  status_read_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && bus_req && !ack_o && !we_i && stat_hit) |=>
      dat_o[`STAT_CAL_BIT] == $past(cal_offset_busy_i) &&
      dat_o[`STAT_LOADED_BIT] == $past(loaded_reg))
    else $error("status read data wrong");

  // a change of input selection shows in the same cycle
  mux_follow_a: assert property ( // RULE_11
    @(posedge clk_i) disable iff (rst_i)
    $changed(core3_sel_d_i) |->
      offsets_o.core3 == (core3_sel_d_i ? trim_field[2] : trim_field[1]))
    else $error("core3 correction lagged its input selection");

endmodule

// *** offset_trim_bank_notes_unused.sv ***
// holds no logic; the whole bank and its checks sit in offset_trim_bank.sv

// *** test_offset_trim_bank.sv ***
// self-checking bench for the offset trim register bank
`timescale 1ns/10ps
module test_offset_trim_bank;
  import offset_trim_pkg::*;
  logic          clk_i, rst_i, ce_i, cyc_i, stb_i, we_i, ack_o;
  logic          cal_offset_busy_i, core2_sel_b_i, core3_sel_d_i;
  logic [13:0]   adr_i;
  logic [3:0]    sel_i;
  logic [31:0]   dat_i, dat_o, st;
  trim_vec_t     fuse_trim_i, tv;
  core_offsets_s offsets_o;
  logic [31:0]   exp_q[$];
  int            bad_count, comparisons, cycles;
  localparam logic [13:0] ADR [5] = '{14'h0cd8, 14'h0ce0, 14'h0ce8,
                                      14'h0cf0, 14'h0cf8};

  offset_trim_bank DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .fuse_trim_i(fuse_trim_i), .cal_offset_busy_i(cal_offset_busy_i),
    .core2_sel_b_i(core2_sel_b_i), .core3_sel_d_i(core3_sel_d_i),
    .offsets_o(offsets_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // read data is taken at the rising edge where ack is sampled high
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      chk("dat_o", exp_q.pop_front(), dat_o);
  end

  // one classic cycle; reads leave their expectation in the queue
  task automatic wb(input logic w, input logic [13:0] a,
                    input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hf;
    if (!w) exp_q.push_back(e);
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  // walk all input selections; outputs must follow in the same cycle
  task automatic chk_sel();
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_i);
      core2_sel_b_i <= s[0];
      core3_sel_d_i <= s[1];
      @(negedge clk_i);
      chk("core2_valid", 32'(s[0]), 32'(offsets_o.core2_valid));
      if (s[0]) chk("core2", 32'(tv[0]), 32'(offsets_o.core2));
      chk("core3", 32'(s[1] ? tv[2] : tv[1]),
          32'(offsets_o.core3));
      chk("core4", 32'(tv[3]), 32'(offsets_o.core4));
      chk("core5", 32'(tv[4]), 32'(offsets_o.core5));
    end
  endtask

  task automatic rd_all();
    for (int i = 0; i < 5; i++)
      wb(1'b0, ADR[i], 32'h0, {20'h0, tv[i]});
  endtask

  task automatic complete_run();
    $display("counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hung handshake ends the run as a failure
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    st = 32'h15;
    {rst_i, ce_i} = 2'b11;
    {cyc_i, stb_i, we_i, cal_offset_busy_i} = 4'h0;
    {core2_sel_b_i, core3_sel_d_i} = 2'b00;
    {adr_i, sel_i, dat_i} = '0;
    {bad_count, comparisons, cycles} = '0;
    fuse_trim_i = trim_vec_t'({xs(), xs()});
    repeat (11) @(posedge clk_i);
    @(negedge clk_i);
    chk("reset 2/3", 32'h0,
        32'({offsets_o.core2, offsets_o.core3}));
    chk("reset 4/5", 32'h0,
        32'({offsets_o.core4, offsets_o.core5}));
    @(posedge clk_i);
    rst_i <= 1'b0;
    tv = fuse_trim_i;
    repeat (2) @(posedge clk_i);
    rd_all();
    chk_sel();
    $display("fuse load test done");
    // reserved bits are always written as zero
    for (int i = 0; i < 5; i++) begin
      tv[i] = 12'(xs());
      wb(1'b1, ADR[i], {20'h0, tv[i]}, 32'h0);
    end
    rd_all();
    chk_sel();
    $display("write test done");
    // gap word and word past the map read zero, writes are dropped
    wb(1'b0, 14'h0cdc, 32'h0, 32'h0);
    wb(1'b1, 14'h0d08, 32'hffff, 32'h0);
    wb(1'b0, 14'h0d08, 32'h0, 32'h0);
    cal_offset_busy_i <= 1'b1;
    wb(1'b0, 14'h0d04, 32'h0, 32'h3);
    // calibration ends before the trims are touched again
    cal_offset_busy_i <= 1'b0;
    $display("map test done");
    // reload picks up whatever the fuses now present
    fuse_trim_i <= trim_vec_t'({xs(), xs()});
    @(negedge clk_i);
    tv = fuse_trim_i;
    wb(1'b1, 14'h0d00, 32'h1, 32'h0);
    rd_all();
    chk_sel();
    $display("reload test done");
    // a second reset clears the trims, then the fuses land again
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("mid reset 4/5", 32'h0,
        32'({offsets_o.core4, offsets_o.core5}));
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rd_all();
    $display("mid-run reset test done");
    // a low clock enable holds a pending read unanswered
    ce_i <= 1'b0;
    fork
      wb(1'b0, ADR[4], 32'h0, {20'h0, tv[4]});
      begin
        repeat (4) @(posedge clk_i);
        chk("ack frozen", 32'h0, 32'(ack_o));
        ce_i <= 1'b1;
      end
    join
    $display("clock enable test done");
    complete_run();
  end
endmodule
